// File: pkg/pdlc_pkg.sv
// Shared constants and types of the pattern diagnostic and loopback control block
package pdlc_pkg;

  // Register addresses on the serial host port
  localparam logic [5:0] ADDR_CHAN_CTRL = 6'h04;
  localparam logic [5:0] ADDR_SRC_STAT = 6'h05;
  localparam logic [5:0] ADDR_ATTEN = 6'h07;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h20;
  localparam logic [5:0] ADDR_IRQ_ST = 6'h21;
  localparam logic [5:0] ADDR_CNT_HI = 6'h30;
  localparam logic [5:0] ADDR_CNT_LO = 6'h31;
  localparam logic [5:0] ADDR_HOLD = 6'h38;
  localparam logic [5:0] ADDR_DEV_ID = 6'h3e;
  localparam logic [5:0] ADDR_SIL_VER = 6'h3f;

  // Channel control fields
  localparam int BIT_E3 = 2;
  localparam int BIT_LOCAL = 3;
  localparam int BIT_REMOTE = 4;
  localparam int BIT_PAT_EN = 5;
  localparam int BIT_ERR_INS = 6;

  // Attenuator control fields
  localparam int BIT_ATT_A = 0;
  localparam int BIT_ATT_PATH = 1;
  localparam int BIT_ATT_B = 2;
  localparam int BIT_ATT_PTR = 3;
  localparam int ATT_W = 4;

  // Status fields
  localparam int BIT_IRQ = 0;
  localparam int BIT_LOSS = 0;
  localparam int BIT_LOSS_EVT = 1;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [ATT_W-1:0] ATT_RST = 4'h0;

  // Serial frame: bit 0 read/write, bits 1..6 address, bit 7 spare, bits 8..15 data
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] FRAME_END = 5'h10;

  // Sequence generator taps
  localparam int LFSR_W = 23;
  localparam int TAP_E3_A = 22;
  localparam int TAP_E3_B = 17;
  localparam int TAP_DS3_A = 14;
  localparam int TAP_DS3_B = 13;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 23'h7fffff;

  // Detector lock thresholds
  localparam logic [5:0] LOCK_GOOD = 6'h20;
  localparam logic [5:0] UNLOCK_BAD = 6'h04;

  // Loopback selection, coded as {remote, local}
  typedef enum logic [1:0] {
    PDLC_LOOP_NORMAL = 2'b00,
    PDLC_LOOP_ANALOG = 2'b01,
    PDLC_LOOP_REMOTE = 2'b10,
    PDLC_LOOP_DIGITAL = 2'b11
  } pdlc_loop_t;

  // Serial port frame states
  typedef enum logic [2:0] {
    PDLC_SP_IDLE = 3'b001,
    PDLC_SP_HEAD = 3'b010,
    PDLC_SP_DATA = 3'b100
  } pdlc_sp_t;

endpackage : pdlc_pkg

// File: verilog/pdlc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module pdlc_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 8
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_in_valid, // Write data valid
  output logic o_in_ready, // Space available
  input wire logic [W-1:0] i_in_data, // Write data
  output logic o_out_valid, // Read data valid
  input wire logic i_out_ready, // Reader takes a word
  output logic [W-1:0] o_out_data // Read data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign o_in_ready = cnt_r != FULL_CNT;
  assign o_out_valid = cnt_r != '0;
  assign o_out_data = mem_r[rp_r];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == LAST_PTR) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == LAST_PTR) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule : pdlc_fifo

// File: verilog/pdlc_top.sv
// Pattern generator/detector, error counter, loopback and attenuator control
`timescale 1ns/10ps
module pdlc_top #(
  parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value
  parameter logic [6:0] VERSION_LOW = 7'h15, // Arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clk, // 50 MHz system clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_host_mode, // Strap: 1 host register control
  input wire logic i_remote_loop_select, // Remote loop select pin
  input wire logic i_local_loop_select, // Local loop select pin
  input wire logic i_sp_cs_n, // Serial port chip select, low active
  input wire logic i_sp_sclk, // Serial port clock
  input wire logic i_sp_sdi, // Serial port data in
  output logic o_sp_sdo, // Serial port data out
  output logic o_sp_sdo_oe, // Serial data out enable
  input wire logic i_tx_clk, // Transmit line clock
  input wire logic i_recovered_rx_clock, // Recovered receive clock
  input wire logic i_rx_line_data, // Recovered receive data
  output logic o_tx_data, // Transmit pattern bit
  output logic o_rx_positive_out, // Receive data out
  output logic o_rx_negative_violation_out, // Sync and error indication
  output logic o_irq_n, // Interrupt request, low active
  output pdlc_pkg::pdlc_loop_t o_loop_mode, // Active loopback mode
  output logic o_atten_bypass, // Attenuator disabled
  output logic o_atten_deep, // 32-bit buffer selected
  output logic o_atten_in_tx_path, // Attenuator in transmit path
  output logic o_atten_ptr_reset // Hold buffer pointers reset
);
  import pdlc_pkg::*;

  // Pin synchronisers
  logic [8:0] pin_raw;
  logic [8:0] pin_m_r;
  logic [8:0] pin_s_r;
  logic [2:0] clk_d_r;
  logic host_s;
  logic rsel_s;
  logic lsel_s;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic txclk_s;
  logic recovered_rx_clock_s;
  logic rxd_s;

  assign pin_raw = {i_host_mode, i_remote_loop_select, i_local_loop_select, i_sp_cs_n,
                    i_sp_sclk, i_sp_sdi, i_tx_clk, i_recovered_rx_clock, i_rx_line_data};
  assign {host_s, rsel_s, lsel_s, cs_n_s, sclk_s, sdi_s, txclk_s, recovered_rx_clock_s, rxd_s} = pin_s_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_m_r <= 9'h020;
      pin_s_r <= 9'h020;
      clk_d_r <= 3'h0;
    end else begin
      pin_m_r <= pin_raw;
      pin_s_r <= pin_m_r;
      clk_d_r <= {sclk_s, txclk_s, recovered_rx_clock_s};
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic tx_rise;
  logic tx_fall;
  logic rx_rise;
  logic rx_fall;

  assign sclk_rise = sclk_s & ~clk_d_r[2];
  assign sclk_fall = ~sclk_s & clk_d_r[2];
  assign tx_rise = txclk_s & ~clk_d_r[1];
  assign tx_fall = ~txclk_s & clk_d_r[1];
  assign rx_rise = recovered_rx_clock_s & ~clk_d_r[0];
  assign rx_fall = ~recovered_rx_clock_s & clk_d_r[0];

  // Serial host port frame
  pdlc_sp_t sp_st_r;
  logic [4:0] sp_cnt_r;
  logic sp_rw_r;
  logic [5:0] sp_addr_r;
  logic [7:0] sp_wdata_r;
  logic [7:0] sp_rdata_r;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic rd_stb;
  logic wr_stb;

  assign rd_stb = (sp_st_r == PDLC_SP_HEAD) & sclk_rise & (sp_cnt_r == HDR_LAST) & sp_rw_r;
  assign wr_stb = (sp_st_r == PDLC_SP_DATA) & sclk_rise & (sp_cnt_r == FRAME_LAST) & ~sp_rw_r;
  assign wr_byte = {sdi_s, sp_wdata_r[7:1]};

  always_ff @(posedge i_clk) begin
    if (i_rst || cs_n_s) begin
      sp_st_r <= PDLC_SP_IDLE;
      sp_cnt_r <= 5'h00;
      sp_rw_r <= 1'b0;
      sp_addr_r <= 6'h00;
      sp_wdata_r <= 8'h00;
    end else begin
      unique case (sp_st_r)
        PDLC_SP_IDLE: begin
          sp_st_r <= PDLC_SP_HEAD;
        end
        PDLC_SP_HEAD: begin
          if (sclk_rise) begin
            sp_cnt_r <= sp_cnt_r + 5'h01;
            if (sp_cnt_r == 5'h00) begin
              sp_rw_r <= sdi_s;
            end else if (sp_cnt_r != HDR_LAST) begin
              sp_addr_r <= {sdi_s, sp_addr_r[5:1]};
            end else begin
              sp_st_r <= PDLC_SP_DATA;
            end
          end
        end
        PDLC_SP_DATA: begin
          if (sclk_rise && sp_cnt_r != FRAME_END) begin
            sp_cnt_r <= sp_cnt_r + 5'h01;
            sp_wdata_r <= wr_byte;
          end
        end
      endcase
    end
  end

  // Read data shifts out LSB first on falling serial clock
  always_ff @(posedge i_clk) begin
    if (i_rst || cs_n_s) begin
      sp_rdata_r <= 8'h00;
      o_sp_sdo <= 1'b0;
      o_sp_sdo_oe <= 1'b0;
    end else if (rd_stb) begin
      sp_rdata_r <= rd_byte;
      o_sp_sdo_oe <= 1'b1;
    end else if (o_sp_sdo_oe && sclk_fall) begin
      o_sp_sdo <= sp_rdata_r[0];
      sp_rdata_r <= {1'b0, sp_rdata_r[7:1]};
    end
  end

  // Control registers
  logic [7:0] ctrl_r;
  logic [ATT_W-1:0] atten_r;
  logic irq_en_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r <= CTRL_RST;
      atten_r <= ATT_RST;
      irq_en_r <= 1'b0;
    end else if (wr_stb) begin
      if (sp_addr_r == ADDR_CHAN_CTRL) begin
        ctrl_r <= wr_byte;
      end
      if (sp_addr_r == ADDR_ATTEN) begin
        atten_r <= wr_byte[ATT_W-1:0];
      end
      if (sp_addr_r == ADDR_IRQ_EN) begin
        irq_en_r <= wr_byte[BIT_IRQ];
      end
    end
  end

  logic pat_on;
  logic e3;
  logic rd_cnt;
  pdlc_loop_t loop_sel;
  logic int_loop;

  assign pat_on = host_s & ctrl_r[BIT_PAT_EN];
  assign e3 = ctrl_r[BIT_E3];
  assign rd_cnt = rd_stb & ((sp_addr_r == ADDR_CNT_HI) | (sp_addr_r == ADDR_CNT_LO));
  assign loop_sel = host_s ? pdlc_loop_t'({ctrl_r[BIT_REMOTE], ctrl_r[BIT_LOCAL]})
                           : pdlc_loop_t'({rsel_s, lsel_s});
  assign int_loop = (o_loop_mode == PDLC_LOOP_ANALOG) | (o_loop_mode == PDLC_LOOP_DIGITAL);

  // Loopback and attenuator outputs; attenuator stays in any loop path
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_loop_mode <= PDLC_LOOP_NORMAL;
      o_atten_bypass <= 1'b0;
      o_atten_deep <= 1'b0;
      o_atten_in_tx_path <= 1'b0;
      o_atten_ptr_reset <= 1'b0;
    end else begin
      o_loop_mode <= loop_sel;
      o_atten_bypass <= atten_r[BIT_ATT_A];
      o_atten_deep <= ~atten_r[BIT_ATT_A] & atten_r[BIT_ATT_B];
      o_atten_in_tx_path <= atten_r[BIT_ATT_PATH];
      o_atten_ptr_reset <= atten_r[BIT_ATT_PTR];
    end
  end

  // Generator feeds the FIFO; transmit clock drains it
  logic [LFSR_W-1:0] gen_r;
  logic gen_bit;
  logic ins_prev_r;
  logic ins_pend_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic push;
  logic tx_bit;

  assign gen_bit = e3 ? gen_r[TAP_E3_A] ^ gen_r[TAP_E3_B]
                      : gen_r[TAP_DS3_A] ^ gen_r[TAP_DS3_B];
  assign push = pat_on & fifo_in_ready;
  assign tx_bit = fifo_out_valid & fifo_out_data;

  pdlc_fifo #(
    .W(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(pat_on),
    .o_in_ready(fifo_in_ready),
    .i_in_data(gen_bit ^ ins_pend_r),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(tx_rise),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst || !pat_on) begin
      gen_r <= LFSR_SEED;
    end else if (push) begin
      gen_r <= {gen_r[LFSR_W-2:0], gen_bit};
    end
  end

  // One error per rising edge of the insert bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ins_prev_r <= 1'b0;
      ins_pend_r <= 1'b0;
    end else begin
      ins_prev_r <= ctrl_r[BIT_ERR_INS];
      if (pat_on && ctrl_r[BIT_ERR_INS] && !ins_prev_r) begin
        ins_pend_r <= 1'b1;
      end else if (push || !pat_on) begin
        ins_pend_r <= 1'b0;
      end
    end
  end

  // Digital loop keeps pattern off the line
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_data <= 1'b0;
    end else if (tx_rise) begin
      o_tx_data <= pat_on & tx_bit & (o_loop_mode != PDLC_LOOP_DIGITAL);
    end
  end

  // Detector, self-synchronising on the received stream, or on the transmit pattern in analog and digital loop
  logic det_edge;
  logic det_fall;
  logic det_bit;
  logic [LFSR_W-1:0] det_r;
  logic det_err;
  logic det_pred;
  logic locked_r;
  logic [5:0] good_r;
  logic [5:0] bad_r;
  logic err_hit;

  assign det_edge = int_loop ? tx_rise : rx_rise;
  assign det_fall = int_loop ? tx_fall : rx_fall;
  assign det_bit = int_loop ? tx_bit : rxd_s;
  assign det_pred = e3 ? det_r[TAP_E3_A] ^ det_r[TAP_E3_B]
                       : det_r[TAP_DS3_A] ^ det_r[TAP_DS3_B];
  assign det_err = det_bit ^ det_pred;
  assign err_hit = pat_on & det_edge & det_err;

  always_ff @(posedge i_clk) begin
    if (i_rst || !pat_on) begin
      det_r <= '0;
      locked_r <= 1'b0;
      good_r <= 6'h00;
      bad_r <= 6'h00;
    end else if (det_edge) begin
      // Free-runs once locked, so one line error is counted once, not thrice
      det_r <= {det_r[LFSR_W-2:0], locked_r ? det_pred : det_bit};
      if (det_err) begin
        good_r <= 6'h00;
        bad_r <= bad_r + 6'h01;
        if (locked_r && bad_r + 6'h01 == UNLOCK_BAD) begin
          locked_r <= 1'b0;
        end
      end else begin
        bad_r <= 6'h00;
        if (!locked_r) begin
          good_r <= good_r + 6'h01;
          if (good_r + 6'h01 == LOCK_GOOD) begin
            locked_r <= 1'b1;
          end
        end
      end
    end
  end

  // Violation output: high out of sync, half-clock pulse per error in sync
  logic viol_r;

  always_ff @(posedge i_clk) begin
    if (i_rst || !pat_on) begin
      viol_r <= 1'b0;
    end else if (err_hit) begin
      viol_r <= 1'b1;
    end else if (det_fall) begin
      viol_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_negative_violation_out <= 1'b0;
      o_rx_positive_out <= 1'b0;
    end else begin
      o_rx_negative_violation_out <= pat_on & (~locked_r | viol_r);
      if (det_edge) begin
        o_rx_positive_out <= det_bit;
      end
    end
  end

  // Loss status and pending service flag
  logic loss;
  logic loss_prev_r;
  logic loss_evt_r;

  assign loss = pat_on & ~locked_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      loss_prev_r <= 1'b0;
      loss_evt_r <= 1'b0;
      o_irq_n <= 1'b1;
    end else begin
      loss_prev_r <= loss;
      if (loss && !loss_prev_r) begin
        loss_evt_r <= 1'b1;
      end else if (rd_stb && sp_addr_r == ADDR_SRC_STAT) begin
        loss_evt_r <= 1'b0;
      end
      o_irq_n <= ~(irq_en_r & loss_evt_r);
    end
  end

  // Error counter with clear-on-read and holding byte
  logic [15:0] cnt_r;
  logic [7:0] hold_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 16'h0000;
    end else if (rd_cnt) begin
      cnt_r <= {15'h0000, err_hit};
    end else if (err_hit && cnt_r != 16'hffff) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hold_r <= 8'h00;
    end else if (rd_stb && sp_addr_r == ADDR_CNT_HI) begin
      hold_r <= cnt_r[7:0];
    end else if (rd_stb && sp_addr_r == ADDR_CNT_LO) begin
      hold_r <= cnt_r[15:8];
    end
  end

  // Read data mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (sp_addr_r)
      ADDR_CHAN_CTRL: rd_byte = ctrl_r;
      ADDR_SRC_STAT: begin
        rd_byte[BIT_LOSS] = loss;
        rd_byte[BIT_LOSS_EVT] = loss_evt_r;
      end
      ADDR_ATTEN: rd_byte[ATT_W-1:0] = atten_r;
      ADDR_IRQ_EN: rd_byte[BIT_IRQ] = irq_en_r;
      ADDR_IRQ_ST: rd_byte[BIT_IRQ] = loss_evt_r;
      ADDR_CNT_HI: rd_byte = cnt_r[15:8];
      ADDR_CNT_LO: rd_byte = cnt_r[7:0];
      ADDR_HOLD: rd_byte = hold_r;
      ADDR_DEV_ID: rd_byte = DEVICE_ID;
      ADDR_SIL_VER: rd_byte = {1'b1, VERSION_LOW};
      default: rd_byte = 8'h00;
    endcase
  end

endmodule : pdlc_top

// File: sim/pdlc_checker.sv
// Port-level assertions for the pattern diagnostic and loopback block
`timescale 1ns/10ps
module pdlc_checker (
  input wire logic i_clk, // Clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_host_mode, // Control strap
  input wire logic i_remote_loop_select, // Loop pin
  input wire logic i_local_loop_select, // Loop pin
  input wire logic i_sp_cs_n, // Frame select
  input wire logic i_tx_clk, // Transmit clock
  input wire logic o_tx_data, // Transmit bit
  input wire logic o_rx_negative_violation_out, // Sync indication
  input wire logic o_irq_n, // Interrupt request
  input wire pdlc_pkg::pdlc_loop_t o_loop_mode, // Loop mode
  input wire logic o_atten_bypass, // Attenuator off
  input wire logic o_atten_deep, // Deep buffer
  input wire logic o_atten_in_tx_path, // Path select
  input wire logic o_atten_ptr_reset // Pointer reset
);
  import pdlc_pkg::*;
  logic [7:0] pin_cnt_r;

  // Cycles spent in pin-strapped mode, saturating
  always_ff @(posedge i_clk) begin
    if (i_rst || i_host_mode) begin
      pin_cnt_r <= 8'h00;
    end else if (pin_cnt_r != 8'hff) begin
      pin_cnt_r <= pin_cnt_r + 8'h01;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_RESET_LEVELS: assert property ($fell(i_rst) |-> o_irq_n && !o_atten_bypass &&
    !o_atten_deep && !o_atten_in_tx_path && !o_atten_ptr_reset && !o_rx_negative_violation_out)
    else $error("outputs not at reset levels");
  AST_DEEP_NOT_BYPASS: assert property (o_atten_deep |-> !o_atten_bypass)
    else $error("deep buffer while bypassed");
  AST_PIN_LOOP: assert property ((!i_host_mode && $stable(i_remote_loop_select) &&
    $stable(i_local_loop_select))[*6] |-> o_loop_mode == {i_remote_loop_select, i_local_loop_select})
    else $error("loop mode does not follow pins");
  AST_PIN_NO_VIOL: assert property ((!i_host_mode)[*6] |-> !o_rx_negative_violation_out)
    else $error("violation output active in pin mode");
  AST_PIN_NO_TX: assert property (pin_cnt_r == 8'hff |-> !o_tx_data)
    else $error("pattern sent in pin mode");
  AST_TX_ON_RISE: assert property ($rose(o_tx_data) |-> $past(i_tx_clk, 2))
    else $error("transmit bit changed away from clock rise");
  AST_ATT_IDLE: assert property ((i_sp_cs_n)[*8] |-> $stable(o_atten_bypass) &&
    $stable(o_atten_deep) && $stable(o_atten_in_tx_path) && $stable(o_atten_ptr_reset))
    else $error("attenuator setting changed without a write");
  AST_LOOP_IDLE: assert property ((i_sp_cs_n && $stable(i_host_mode) &&
    $stable(i_remote_loop_select) && $stable(i_local_loop_select))[*8] |-> $stable(o_loop_mode))
    else $error("loop mode changed without a cause");
endmodule : pdlc_checker

// File: sim/pdlc_line_model.sv
// Line-side partner: free-running line clocks with a one-bit data loop
`timescale 1ns/10ps
module pdlc_line_model #(
  parameter int HALF = 6
) (
  input wire logic i_clk, // System clock
  input wire logic i_stall, // Hold line clocks still
  input wire logic i_invert, // Corrupt looped data
  input wire logic i_tx_data, // Bit from the block
  output logic o_tx_clk, // Transmit clock
  output logic o_rx_clk, // Recovered clock
  output logic o_rx_data // Recovered data
);
  int cnt = 0;
  logic cap = 1'b0;
  initial begin
    o_tx_clk = 1'b0;
    o_rx_data = 1'b0;
  end
  assign o_rx_clk = ~o_tx_clk;
  always @(posedge i_clk) begin
    if (!i_stall) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        o_tx_clk <= ~o_tx_clk;
        // New bit while the receive clock falls
        if (!o_tx_clk) o_rx_data <= cap ^ i_invert;
      end else begin
        cnt <= cnt + 1;
      end
      if (o_tx_clk && cnt == HALF - 2) cap <= i_tx_data;
    end
  end
endmodule : pdlc_line_model

// File: sim/pdlc_top_bench.sv
// Self-checking bench for the pattern diagnostic and loopback block
`timescale 1ns/10ps
module pdlc_top_bench;
  import pdlc_pkg::*;
  localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary value
  localparam logic [6:0] VER_LOW = 7'h2a; // Arbitrary value
  logic i_clk = 1'b0, i_rst = 1'b1, host = 1'b1, rem = 1'b0, loc = 1'b0;
  logic cs_n = 1'b1, sclk = 1'b0, sdi = 1'b0, stall = 1'b0, inv = 1'b0;
  logic sdo, sdo_oe, tx_clk, rx_clk, rx_data, tx_d, rx_pos, viol, irq_n;
  logic bypass, deep, in_tx, ptr, got_v = 1'b0;
  pdlc_loop_t loop_mode;
  logic [7:0] got = 8'h00, q = 8'h00;
  logic [7:0] exp_q[$];
  string nm_q[$];
  int bad_count = 0, n_checks = 0, cyc = 0, pul = 0, wid = 0, maxw = 0, i, k;
  logic [31:0] seed = 32'h8e48bee5;
  logic [5:0] a;

  always #10 i_clk = ~i_clk;

  pdlc_top #(.DEVICE_ID(DEV_ID), .VERSION_LOW(VER_LOW)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_host_mode(host), .i_remote_loop_select(rem),
    .i_local_loop_select(loc), .i_sp_cs_n(cs_n), .i_sp_sclk(sclk), .i_sp_sdi(sdi),
    .o_sp_sdo(sdo), .o_sp_sdo_oe(sdo_oe), .i_tx_clk(tx_clk), .i_recovered_rx_clock(rx_clk),
    .i_rx_line_data(rx_data), .o_tx_data(tx_d), .o_rx_positive_out(rx_pos),
    .o_rx_negative_violation_out(viol), .o_irq_n(irq_n), .o_loop_mode(loop_mode),
    .o_atten_bypass(bypass), .o_atten_deep(deep), .o_atten_in_tx_path(in_tx),
    .o_atten_ptr_reset(ptr));

  pdlc_line_model lm (.i_clk(i_clk), .i_stall(stall), .i_invert(inv), .i_tx_data(tx_d),
    .o_tx_clk(tx_clk), .o_rx_clk(rx_clk), .o_rx_data(rx_data));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] e);
    n_checks++;
    if (seen !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, seen);
    end
  endtask : chk

  task tally_and_finish;
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // One framed access; read data sampled late in the high phase of each of the eight data bits
  task automatic xfer(input logic rd, input logic [5:0] ad, input logic [7:0] d);
    logic [15:0] f;
    f = {d, 1'b0, ad, rd};
    cs_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    for (int b = 0; b < 16; b++) begin
      sdi <= f[b];
      repeat (6) @(posedge i_clk);
      sclk <= 1'b1;
      repeat (6) @(posedge i_clk);
      if (b >= 8) q[b-8] = sdo;
      sclk <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
    cs_n <= 1'b1;
    sdi <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask : xfer

  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    xfer(1'b0, ad, d);
  endtask : wr

  task automatic rd(input logic [5:0] ad, input logic [7:0] e, input string n);
    exp_q.push_back(e);
    nm_q.push_back(n);
    xfer(1'b1, ad, 8'h00);
    got <= q;
    got_v <= 1'b1;
    @(posedge i_clk);
    got_v <= 1'b0;
  endtask : rd

  task automatic waitv(input logic lvl, input int lim);
    for (k = 0; k < lim && viol !== lvl; k++) @(posedge i_clk);
  endtask : waitv

  // Result watcher, pulse measurement and run limit
  always @(posedge i_clk) begin
    if (got_v) chk(nm_q.pop_front(), got, exp_q.pop_front());
    wid = (viol === 1'b1) ? wid + 1 : 0;
    if (wid == 1) pul++;
    if (wid > maxw) maxw = wid;
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk("irq_n", {7'h0, irq_n}, 8'h01);
    rd(ADDR_IRQ_EN, 8'h00, "irq_en");
    wr(ADDR_IRQ_ST, 8'hff);
    rd(ADDR_IRQ_ST, 8'h00, "irq_st");
    wr(ADDR_DEV_ID, 8'h00);
    rd(ADDR_DEV_ID, DEV_ID, "dev_id");
    wr(ADDR_SIL_VER, 8'h00);
    rd(ADDR_SIL_VER, {1'b1, VER_LOW}, "version");
    for (i = 0; i < 16; i++) begin
      wr(ADDR_ATTEN, 8'(i));
      chk("atten", {4'h0, ptr, in_tx, deep, bypass},
          {4'h0, i[3], i[1], ~i[0] & i[2], i[0]});
      rd(ADDR_ATTEN, 8'(i), "atten_rd");
    end
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      a = 6'h22 + 6'(seed % 14);
      wr(a, seed[15:8]);
      rd(a, 8'h00, "unmapped");
    end
    host <= 1'b0;
    for (i = 0; i < 4; i++) begin
      {rem, loc} <= 2'(i);
      repeat (8) @(posedge i_clk);
      chk("pin_loop", {6'h0, loop_mode}, 8'(i));
    end
    wr(ADDR_CHAN_CTRL, 8'h20);
    repeat (300) @(posedge i_clk);
    chk("pin_quiet", {6'h0, tx_d, viol}, 8'h00);
    wr(ADDR_CHAN_CTRL, 8'h00);
    host <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(ADDR_CHAN_CTRL, 8'(i << 3));
      chk("reg_loop", {6'h0, loop_mode}, 8'(i));
    end
    wr(ADDR_IRQ_EN, 8'h01);
    wr(ADDR_CHAN_CTRL, 8'h20);
    chk("sync_lost", {6'h0, irq_n, viol}, 8'h01);
    rd(ADDR_IRQ_ST, 8'h01, "irq_st");
    waitv(1'b0, 3000);
    rd(ADDR_SRC_STAT, 8'h02, "loss_event");
    rd(ADDR_SRC_STAT, 8'h00, "loss_clear");
    chk("irq_idle", {7'h0, irq_n}, 8'h01);
    xfer(1'b1, ADDR_CNT_HI, 8'h00);
    stall <= 1'b1;
    repeat (300) @(posedge i_clk);
    stall <= 1'b0;
    repeat (300) @(posedge i_clk);
    rd(ADDR_CNT_LO, 8'h00, "cnt_stall");
    rd(ADDR_HOLD, 8'h00, "hold_stall");
    pul = 0;
    maxw = 0;
    wr(ADDR_CHAN_CTRL, 8'h60);
    repeat (400) @(posedge i_clk);
    rd(ADDR_CNT_LO, 8'h01, "cnt_lo");
    rd(ADDR_HOLD, 8'h00, "hold_hi");
    wr(ADDR_CHAN_CTRL, 8'h60);
    repeat (400) @(posedge i_clk);
    rd(ADDR_CNT_HI, 8'h00, "cnt_held");
    rd(ADDR_HOLD, 8'h00, "hold_held");
    wr(ADDR_CHAN_CTRL, 8'h20);
    wr(ADDR_CHAN_CTRL, 8'h60);
    repeat (400) @(posedge i_clk);
    rd(ADDR_CNT_HI, 8'h00, "cnt_hi");
    rd(ADDR_HOLD, 8'h01, "hold_lo");
    chk("pulses", 8'(pul), 8'h02);
    chk("pulse_len", {7'h0, maxw > 0 && maxw <= 8}, 8'h01);
    inv <= 1'b1;
    wr(ADDR_CHAN_CTRL, 8'h2c);
    repeat (600) @(posedge i_clk);
    waitv(1'b0, 4000);
    chk("analog_lock", {7'h0, viol}, 8'h00);
    wr(ADDR_CHAN_CTRL, 8'h24);
    waitv(1'b1, 600);
    chk("line_bad", {7'h0, viol}, 8'h01);
    inv <= 1'b0;
    waitv(1'b0, 4000);
    chk("e3_lock", {7'h0, viol}, 8'h00);
    wr(ADDR_CHAN_CTRL, 8'h38);
    repeat (300) @(posedge i_clk);
    chk("digital_tx", {7'h0, tx_d}, 8'h00);
    tally_and_finish();
  end
endmodule : pdlc_top_bench

bind pdlc_top pdlc_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_host_mode(i_host_mode),
  .i_remote_loop_select(i_remote_loop_select), .i_local_loop_select(i_local_loop_select),
  .i_sp_cs_n(i_sp_cs_n), .i_tx_clk(i_tx_clk), .o_tx_data(o_tx_data),
  .o_rx_negative_violation_out(o_rx_negative_violation_out), .o_irq_n(o_irq_n),
  .o_loop_mode(o_loop_mode), .o_atten_bypass(o_atten_bypass), .o_atten_deep(o_atten_deep),
  .o_atten_in_tx_path(o_atten_in_tx_path), .o_atten_ptr_reset(o_atten_ptr_reset));
